/* include/sector_ecc_pkg.sv */
// Shared constants, carriers and field arithmetic for the sector encoder
package sector_ecc_pkg;
  // Frame layout, in bytes
  localparam int ROW_BYTES     = 172;
  localparam int FRAME_ROWS    = 12;
  localparam int FRAME_BYTES   = 2064;
  localparam int HCHK_START    = 4;
  localparam int COPY_START    = 6;
  localparam int COPY_LAST     = 11;
  localparam int USER_START    = 12;
  localparam int CHK_START     = 2060;
  localparam int HDR_CHK_BYTES = 2;
  // Block layout
  localparam int BLK_SECTORS   = 16;
  localparam int DATA_ROWS     = 192;
  localparam int OUT_PAR       = 16;
  localparam int IN_PAR        = 10;
  localparam int BLK_ROWS      = 208;
  localparam int BLK_COLS      = 182;
  localparam int REC_ROWS      = 13;
  localparam int CODE_BITS     = 16;
  // Identifier fields
  localparam int ID_LINK_BIT   = 25;
  localparam int PRESET_MSB    = 7;
  localparam int PRESET_LSB    = 4;
  // Polynomials
  localparam logic [8:0]  GF_POLY  = 9'h11D;
  localparam logic [31:0] CRC_POLY = 32'h80000011;
  // Scrambler presets by index 0..F
  localparam logic [0:15][14:0] SCR_PRESET = {
    15'h0001, 15'h5500, 15'h0002, 15'h2A00, 15'h0004, 15'h5400, 15'h0008, 15'h2800,
    15'h0010, 15'h5000, 15'h0020, 15'h2001, 15'h0040, 15'h4002, 15'h0080, 15'h0005};

  typedef enum logic [1:0] {CS1, CS2, CS3, CS4} code_state_t;

  typedef struct packed {
    logic [31:0] id;
    logic [47:0] copy;
    logic        copy_given;
  } sector_hdr_t;

  typedef struct packed {
    logic [7:0]  data;
    code_state_t state;
  } code_req_t;

  typedef struct packed {
    logic [15:0] code;
    code_state_t next;
  } code_entry_t;

  // Field product modulo the field polynomial
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY[7:0]) : {x[6:0], 1'b0};
    end
    return p;
  endfunction

  // Low coefficients of the product of (x + alpha^k), k below n
  function automatic logic [15:0][7:0] gen_poly(input int n);
    logic [16:0][7:0] g;
    logic [7:0]       a;
    g    = '0;
    g[0] = 8'h01;
    a    = 8'h01;
    for (int k = 0; k < n; k++) begin
      for (int i = 16; i > 0; i--) g[i] = g[i-1] ^ gf_mul(g[i], a);
      g[0] = gf_mul(g[0], a);
      a    = gf_mul(a, 8'h02);
    end
    return g[15:0];
  endfunction

  // Check word update, most significant bit first, no reflection
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c  = {c[30:0], 1'b0} ^ ({32{fb}} & CRC_POLY);
    end
    return c;
  endfunction

  // Eight single shifts of the scrambler
  function automatic logic [14:0] scr_shift8(input logic [14:0] r);
    for (int i = 0; i < 8; i++) r = {r[13:0], r[14] ^ r[10]};
    return r;
  endfunction
endpackage

/* src/rs_remainder.sv */
// Reed-Solomon remainder shift register with a configurable parity count
`timescale 1ns/100ps
module rs_remainder #(
  parameter int NPAR = 2
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            sys_rst,
  // Byte feed
  input  wire logic            start,
  input  wire logic            en,
  input  wire logic [7:0]      din,
  // Remainder, highest power in the top byte
  output logic [NPAR-1:0][7:0] par
);
  import sector_ecc_pkg::*;

  localparam logic [15:0][7:0] GEN = gen_poly(NPAR);

  logic [NPAR-1:0][7:0] par_q;
  logic [NPAR-1:0][7:0] par_d;
  logic [NPAR-1:0][7:0] base;
  logic [7:0]           fb;

  // Start treats the old remainder as zero so a new codeword needs no idle cycle
  assign base = start ? '0 : par_q;
  assign fb   = din ^ base[NPAR-1];
  assign par  = par_q;

  always_comb begin
    par_d = par_q;
    if (en) begin
      par_d[0] = gf_mul(fb, GEN[0]);
      for (int i = 1; i < NPAR; i++) begin
        par_d[i] = base[i-1] ^ gf_mul(fb, GEN[i]);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) par_q <= '0;
    else par_q <= par_d;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  rs_seed_a: assert property ((en && start) |=> par_q[0] == gf_mul($past(din), GEN[0]))
    else $error("remainder not seeded from first byte");
  rs_shift_a: assert property ((en && !start && din == par_q[NPAR-1]) |=> par_q == ($past(par_q) << 8))
    else $error("zero feedback did not shift remainder");
  rs_hold_a: assert property (!en |=> $stable(par_q))
    else $error("remainder changed without feed");
endmodule

/* src/rll_nrzi_tx.sv */
// Four-state byte to code word modulator with NRZI channel output
`timescale 1ns/100ps
module rll_nrzi_tx (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // Byte stream
  input  wire logic                        byte_valid,
  input  wire logic [7:0]                  byte_data,
  output logic                             byte_ready,
  // Code table lookup
  output sector_ecc_pkg::code_req_t        lk_req,
  input  wire sector_ecc_pkg::code_entry_t lk_resp,
  // Channel bits
  output logic                             chan_bit,
  output logic                             chan_valid
);
  import sector_ecc_pkg::*;

  code_state_t          st_q;
  logic [CODE_BITS-1:0] sh_q;
  logic [3:0]           cnt_q;
  logic                 busy_q;
  logic                 lvl_q;
  logic                 vld_q;
  logic                 take;

  // Ready on the last bit keeps code words back to back
  assign byte_ready = !busy_q || cnt_q == 4'(CODE_BITS - 1);
  assign take       = byte_valid && byte_ready;
  assign lk_req     = {byte_data, st_q};
  assign chan_bit   = lvl_q;
  assign chan_valid = vld_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q   <= CS1;
      sh_q   <= '0;
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
      lvl_q  <= 1'b0;
      vld_q  <= 1'b0;
    end else begin
      vld_q <= busy_q;
      if (busy_q) lvl_q <= lvl_q ^ sh_q[CODE_BITS-1];
      if (take) begin
        sh_q   <= lk_resp.code;
        st_q   <= lk_resp.next;
        cnt_q  <= 4'h0;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        sh_q   <= {sh_q[CODE_BITS-2:0], 1'b0};
        cnt_q  <= cnt_q + 4'h1;
        busy_q <= cnt_q != 4'hF;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence code_busy_s;
    (!byte_ready) [*8];
  endsequence

  word_len_a: assert property (take |=> code_busy_s ##8 byte_ready)
    else $error("code word not sixteen bits long");
  next_state_a: assert property (take |=> st_q == $past(lk_resp.next))
    else $error("next code state not taken");
  nrzi_flip_a: assert property ($past(busy_q) |-> lvl_q == ($past(lvl_q) ^ $past(sh_q[CODE_BITS-1])))
    else $error("channel level not toggled on one");
endmodule

/* src/sector_ecc_encoder.sv */
// Sector formatter: frame checks, scrambling, product code, interleave, modulation
`timescale 1ns/100ps
module sector_ecc_encoder (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // Sector header
  input  wire sector_ecc_pkg::sector_hdr_t hdr_in,
  input  wire logic                        hdr_valid,
  output logic                             hdr_ready,
  // User bytes
  input  wire logic [7:0]                  user_byte,
  input  wire logic                        user_valid,
  output logic                             user_ready,
  // Code table lookup
  output sector_ecc_pkg::code_req_t        lk_req,
  input  wire sector_ecc_pkg::code_entry_t lk_resp,
  // Channel bits
  output logic                             chan_bit,
  output logic                             chan_valid
);
  import sector_ecc_pkg::*;

  typedef enum logic [2:0] {PH_HDR, PH_FRAME, PH_OUTER, PH_INNER, PH_EMIT} phase_t;

  phase_t      ph_q;
  phase_t      ph_d;
  sector_hdr_t hdr_q;
  sector_hdr_t hdr_d;
  logic [11:0] k_q;
  logic [11:0] k_d;
  logic [7:0]  row_q;
  logic [7:0]  row_d;
  logic [7:0]  col_q;
  logic [7:0]  col_d;
  logic [3:0]  sec_q;
  logic [3:0]  sec_d;
  logic [3:0]  grp_q;
  logic [3:0]  grp_d;
  logic [3:0]  sub_q;
  logic [3:0]  sub_d;
  logic [31:0] crc_q;
  logic [31:0] crc_d;
  logic [14:0] scr_q;
  logic [14:0] scr_d;

  // Whole block is held because outer parity needs every data row first
  logic [7:0] blk_mem [BLK_ROWS*BLK_COLS];

  logic                   is_user;
  logic                   step;
  logic                   hdr_take;
  logic                   copy_zero;
  logic [2:0]             copy_idx;
  logic [7:0]             id_b;
  logic [7:0]             copy_b;
  logic [7:0]             chk_b;
  logic [7:0]             fr_byte;
  logic [7:0]             fr_out;
  logic [1:0][7:0]        hpar;
  logic [OUT_PAR-1:0][7:0] opar;
  logic [IN_PAR-1:0][7:0] ipar;
  logic                   orow_par;
  logic                   icol_par;
  logic [7:0]             opar_b;
  logic [7:0]             ipar_b;
  logic                   wr_en;
  logic [7:0]             wr_data;
  logic [15:0]            wr_addr;
  logic [7:0]             src_row;
  logic [7:0]             rd_row;
  logic [15:0]            rd_addr;
  logic [7:0]             rd_data;
  logic                   last_rcol;
  logic                   last_col;
  logic                   last_row;
  logic                   emit_valid;
  logic                   mod_ready;

  // Frame assembly
  assign hdr_ready  = ph_q == PH_HDR;
  assign hdr_take   = hdr_valid && hdr_ready;
  assign is_user    = k_q >= USER_START && k_q < CHK_START;
  assign user_ready = ph_q == PH_FRAME && is_user;
  assign step       = ph_q == PH_FRAME && (!is_user || user_valid);
  assign copy_idx   = 3'(COPY_LAST - k_q);
  assign copy_zero  = !hdr_q.copy_given || hdr_q.id[ID_LINK_BIT];
  assign id_b       = hdr_q.id[{~k_q[1:0], 3'b000} +: 8];
  assign copy_b     = copy_zero ? 8'h00 : hdr_q.copy[{copy_idx, 3'b000} +: 8];
  assign chk_b      = crc_q[{~k_q[1:0], 3'b000} +: 8];
  assign fr_byte    = (k_q < HCHK_START) ? id_b :
                      (k_q < COPY_START) ? hpar[~k_q[0]] :
                      (k_q < USER_START) ? copy_b :
                      is_user ? user_byte : chk_b;
  // The check word sees the unscrambled bytes
  assign fr_out     = is_user ? (user_byte ^ scr_q[7:0]) : fr_byte;

  // Parity placement; 192 has a clear low nibble, so it indexes parity rows
  assign orow_par = row_q >= DATA_ROWS;
  assign icol_par = col_q >= ROW_BYTES;
  assign opar_b   = opar[~row_q[3:0]];
  assign ipar_b   = ipar[4'(BLK_COLS - 1 - col_q)];

  // Memory ports
  assign wr_en   = step || (ph_q == PH_OUTER && orow_par) || (ph_q == PH_INNER && icol_par);
  assign wr_data = ph_q == PH_FRAME ? fr_out : ph_q == PH_OUTER ? opar_b : ipar_b;
  assign wr_addr = 16'(row_q * BLK_COLS + col_q);
  assign src_row = (sub_q == REC_ROWS - 1) ? 8'(DATA_ROWS + grp_q) : 8'(grp_q * FRAME_ROWS + sub_q);
  assign rd_row  = ph_q == PH_EMIT ? src_row : row_q;
  assign rd_addr = 16'(rd_row * BLK_COLS + col_q);
  assign rd_data = blk_mem[rd_addr];

  assign last_rcol  = col_q == ROW_BYTES - 1;
  assign last_col   = col_q == BLK_COLS - 1;
  assign last_row   = row_q == BLK_ROWS - 1;
  assign emit_valid = ph_q == PH_EMIT;

  always_ff @(posedge clk_sys) begin
    if (wr_en) blk_mem[wr_addr] <= wr_data;
  end

  rs_remainder #(
    .NPAR (HDR_CHK_BYTES)
  ) u_hdr_chk (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (k_q == 12'h000),
    .en      (step && k_q < HCHK_START),
    .din     (id_b),
    .par     (hpar)
  );

  rs_remainder #(
    .NPAR (OUT_PAR)
  ) u_outer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (row_q == 8'h00),
    .en      (ph_q == PH_OUTER && !orow_par),
    .din     (rd_data),
    .par     (opar)
  );

  rs_remainder #(
    .NPAR (IN_PAR)
  ) u_inner (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (col_q == 8'h00),
    .en      (ph_q == PH_INNER && !icol_par),
    .din     (rd_data),
    .par     (ipar)
  );

  rll_nrzi_tx u_mod (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .byte_valid (emit_valid),
    .byte_data  (rd_data),
    .byte_ready (mod_ready),
    .lk_req     (lk_req),
    .lk_resp    (lk_resp),
    .chan_bit   (chan_bit),
    .chan_valid (chan_valid)
  );

  always_comb begin
    ph_d  = ph_q;
    hdr_d = hdr_q;
    k_d   = k_q;
    row_d = row_q;
    col_d = col_q;
    sec_d = sec_q;
    grp_d = grp_q;
    sub_d = sub_q;
    crc_d = crc_q;
    scr_d = scr_q;
    case (ph_q)
      PH_HDR: begin
        if (hdr_valid) begin
          hdr_d = hdr_in;
          ph_d  = PH_FRAME;
          k_d   = 12'h000;
          crc_d = 32'h00000000;
          scr_d = SCR_PRESET[hdr_in.id[PRESET_MSB:PRESET_LSB]];
        end
      end
      PH_FRAME: begin
        if (step) begin
          if (k_q < CHK_START) crc_d = crc_byte(crc_q, fr_byte);
          if (is_user) scr_d = scr_shift8(scr_q);
          col_d = last_rcol ? 8'h00 : col_q + 8'h01;
          if (last_rcol) row_d = row_q + 8'h01;
          k_d = k_q + 12'h001;
          if (k_q == FRAME_BYTES - 1) begin
            k_d   = 12'h000;
            sec_d = sec_q + 4'h1;
            ph_d  = PH_HDR;
            if (sec_q == 4'(BLK_SECTORS - 1)) begin
              ph_d  = PH_OUTER;
              row_d = 8'h00;
              col_d = 8'h00;
            end
          end
        end
      end
      PH_OUTER: begin
        row_d = row_q + 8'h01;
        if (last_row) begin
          row_d = 8'h00;
          col_d = col_q + 8'h01;
          if (last_rcol) begin
            ph_d  = PH_INNER;
            col_d = 8'h00;
          end
        end
      end
      PH_INNER: begin
        col_d = col_q + 8'h01;
        if (last_col) begin
          col_d = 8'h00;
          row_d = row_q + 8'h01;
          if (last_row) begin
            ph_d  = PH_EMIT;
            row_d = 8'h00;
            grp_d = 4'h0;
            sub_d = 4'h0;
          end
        end
      end
      PH_EMIT: begin
        if (mod_ready) begin
          col_d = col_q + 8'h01;
          if (last_col) begin
            col_d = 8'h00;
            sub_d = sub_q + 4'h1;
            if (sub_q == 4'(REC_ROWS - 1)) begin
              sub_d = 4'h0;
              grp_d = grp_q + 4'h1;
              if (grp_q == 4'(BLK_SECTORS - 1)) ph_d = PH_HDR;
            end
          end
        end
      end
      default: ph_d = PH_HDR;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ph_q  <= PH_HDR;
      hdr_q <= '0;
      k_q   <= 12'h000;
      row_q <= 8'h00;
      col_q <= 8'h00;
      sec_q <= 4'h0;
      grp_q <= 4'h0;
      sub_q <= 4'h0;
      crc_q <= 32'h00000000;
      scr_q <= 15'h0000;
    end else begin
      ph_q  <= ph_d;
      hdr_q <= hdr_d;
      k_q   <= k_d;
      row_q <= row_d;
      col_q <= col_d;
      sec_q <= sec_d;
      grp_q <= grp_d;
      sub_q <= sub_d;
      crc_q <= crc_d;
      scr_q <= scr_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  ready_excl_a: assert property (!(hdr_ready && user_ready))
    else $error("header and user ready together");
  copy_link_a: assert property ((step && k_q >= COPY_START && k_q < USER_START && hdr_q.id[ID_LINK_BIT])
                                |-> wr_data == 8'h00)
    else $error("copy field not zero in link sector");
  chk_last_a: assert property ((step && k_q == FRAME_BYTES - 1) |-> wr_data == crc_q[7:0])
    else $error("check word low byte misplaced");
  preset_load_a: assert property (hdr_take |=> scr_q == SCR_PRESET[hdr_q.id[PRESET_MSB:PRESET_LSB]])
    else $error("scrambler preset wrong");
  ilv_par_a: assert property ((emit_valid && sub_q == REC_ROWS - 1) |-> rd_row >= DATA_ROWS)
    else $error("parity row not interleaved");
endmodule

/* testbench/chan_sink.sv */
// Code table stand-in and NRZI channel receiver for the sector encoder
`timescale 1ns/100ps
module chan_sink (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // Code table lookup
  input  wire sector_ecc_pkg::code_req_t lk_req,
  output sector_ecc_pkg::code_entry_t    lk_resp,
  // Channel bits
  input  wire logic                      chan_bit,
  input  wire logic                      chan_valid
);
  import sector_ecc_pkg::*;
  logic [15:0] word_q;
  logic [3:0]  cnt_q;
  logic        lvl_q;
  logic [15:0] words [$];
  wire  logic  code_bit = chan_bit ^ lvl_q;

  // Arbitrary table: only the lookup plumbing is judged here, not the run-length limits
  assign lk_resp.code = {lk_req.data ^ 8'h5A, 6'h00, lk_req.state};
  assign lk_resp.next = code_state_t'(lk_req.state + lk_req.data[1:0]);

  // A one bit shows as a change of level
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      lvl_q  <= 1'b0;
      cnt_q  <= 4'h0;
      word_q <= 16'h0000;
    end else if (chan_valid) begin
      lvl_q  <= chan_bit;
      word_q <= {word_q[14:0], code_bit};
      cnt_q  <= cnt_q + 4'h1;
      if (cnt_q == 4'hF) words.push_back({word_q[14:0], code_bit});
    end
  end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the sector encoder: handshakes, frame contents, parity and the first 20 words of the first emitted row
`timescale 1ns/100ps
module testbench;
  import sector_ecc_pkg::*;
  logic        clk_sys;
  logic        sys_rst;
  sector_hdr_t hdr_in;
  logic        hdr_valid;
  logic        hdr_ready;
  logic [7:0]  user_byte;
  logic        user_valid;
  logic        user_ready;
  code_req_t   lk_req;
  code_entry_t lk_resp;
  logic        chan_bit;
  logic        chan_valid;
  int          num_errors;
  int          cmp_count;
  logic [7:0]  scr_tab [2048];

  sector_ecc_encoder dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hdr_in(hdr_in), .hdr_valid(hdr_valid),
    .hdr_ready(hdr_ready), .user_byte(user_byte), .user_valid(user_valid), .user_ready(user_ready),
    .lk_req(lk_req), .lk_resp(lk_resp), .chan_bit(chan_bit), .chan_valid(chan_valid));
  chan_sink model (.clk_sys(clk_sys), .sys_rst(sys_rst), .lk_req(lk_req), .lk_resp(lk_resp),
    .chan_bit(chan_bit), .chan_valid(chan_valid));

  always #2 clk_sys = ~clk_sys;

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ a;
      a = a[7] ? ({a[6:0], 1'b0} ^ 8'h1D) : {a[6:0], 1'b0};
    end
    return p;
  endfunction

  function automatic logic [14:0] scr8(input logic [14:0] r);
    for (int i = 0; i < 8; i++) r = {r[13:0], r[14] ^ r[10]};
    return r;
  endfunction

  function automatic logic [17:0] lookup(input logic [7:0] d, input logic [1:0] st);
    return {d ^ 8'h5A, 6'h00, st, 2'(st + d[1:0])};
  endfunction

  // Sector 1 is a data sector, the rest link sectors; aligned block start, preset index A throughout
  function automatic logic [31:0] id_of(input int s);
    return {(s == 1) ? 8'h00 : 8'h02, 24'h0000A0 + 24'(s)};
  endfunction

  function automatic logic [7:0] data_of(input int s, input int k);
    return 8'(k * 7 + s);
  endfunction

  // Frame byte before scrambling; sector 2 is sent without a copy value
  function automatic logic [7:0] raw_byte(input int s, input int k);
    logic [31:0] id;
    logic [7:0]  r1;
    logic [7:0]  r0;
    logic [7:0]  fb;
    id = id_of(s);
    r1 = 8'h00;
    r0 = 8'h00;
    for (int i = 0; i < 4; i++) begin
      fb = id[31-8*i -: 8] ^ r1;
      r1 = r0 ^ gmul(fb, 8'h03);
      r0 = gmul(fb, 8'h02);
    end
    if (k < 4) return id[31-8*k -: 8];
    if (k == 4) return r1;
    if (k == 5) return r0;
    if (k < 12) return (id[25] || s == 2) ? 8'h00 : 8'(48'h112233445566 >> (8 * (11 - k)));
    return data_of(s, k - 12);
  endfunction

  // Long division of the frame bits followed by 32 zeros by x^32 + x^31 + x^4 + 1
  function automatic logic [31:0] crc_of(input int s);
    logic [31:0] r;
    logic [7:0]  d;
    logic        top;
    r = 32'h00000000;
    for (int k = 0; k < 2064; k++) begin
      d = (k < 2060) ? raw_byte(s, k) : 8'h00;
      for (int i = 7; i >= 0; i--) begin
        top = r[31];
        r   = {r[30:0], d[i]} ^ (top ? 32'h80000011 : 32'h00000000);
      end
    end
    return r;
  endfunction

  // Byte of a data row as the frame phase stores it
  function automatic logic [7:0] blk_byte(input int row, input int col);
    int k;
    k = (row % 12) * 172 + col;
    if (k < 12) return raw_byte(row / 12, k);
    return raw_byte(row / 12, k) ^ scr_tab[k - 12];
  endfunction

  task automatic t_reset();
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    check("hdr_ready after reset", 32'h1, 32'(hdr_ready));
    check("user_ready after reset", 32'h0, 32'(user_ready));
    check("chan_valid after reset", 32'h0, 32'(chan_valid));
  endtask

  task automatic t_sector(input int s);
    int n;
    int k;
    check("hdr_ready before header", 32'h1, 32'(hdr_ready));
    hdr_valid <= 1'b1;
    hdr_in    <= '{id: id_of(s), copy: 48'h112233445566, copy_given: s != 2};
    @(posedge clk_sys);
    hdr_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (user_ready !== 1'b1 && n < 40);
    check("edges to first user slot", 32'd13, 32'(n));
    user_valid <= 1'b1;
    user_byte  <= data_of(s, 0);
    k = 0;
    n = 0;
    // One idle cycle after D99 proves the slots wait for the source
    while (k < 2048 && n < 3000) begin
      @(posedge clk_sys);
      n++;
      if (user_valid === 1'b1 && user_ready === 1'b1) k++;
      user_valid <= (k != 100 || user_valid === 1'b0) && k < 2048;
      user_byte  <= data_of(s, k);
    end
    check("edges over user slots", 32'd2049, 32'(n));
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hdr_ready !== 1'b1 && n < 8);
    if (s < 15) check("edges to next header", 32'd5, 32'(n));
    else check("hdr_ready while block builds", 32'h0, 32'(hdr_ready));
  endtask

  task automatic t_first_row();
    logic [7:0]  b [20];
    logic [7:0]  r1;
    logic [7:0]  r0;
    logic [7:0]  fb;
    logic [14:0] r;
    logic [1:0]  st;
    logic [17:0] e;
    logic [31:0] id;
    int          n;
    id = id_of(0);
    r1 = 8'h00;
    r0 = 8'h00;
    for (int i = 0; i < 4; i++) begin
      b[i] = id[31-8*i -: 8];
      fb   = b[i] ^ r1;
      r1   = r0 ^ gmul(fb, 8'h03);
      r0   = gmul(fb, 8'h02);
    end
    b[4] = r1;
    b[5] = r0;
    // Link sector: the supplied copy value must not reach the frame
    for (int i = 6; i < 12; i++) b[i] = 8'h00;
    r = 15'h0020;
    for (int i = 12; i < 20; i++) begin
      b[i] = data_of(0, i - 12) ^ r[7:0];
      r    = scr8(r);
    end
    n = 0;
    while (model.words.size() < 20 && n < 90000) begin
      @(posedge clk_sys);
      n++;
    end
    check("emitted words", 32'd20, 32'(model.words.size()));
    st = 2'b00;
    for (int i = 0; i < 20; i++) begin
      e = lookup(b[i], st);
      check("code word", 32'(e[17:2]), 32'(model.words[i]));
      st = e[1:0];
    end
  endtask

  // Header, copy field and check word of the first three frames as stored in the block
  task automatic t_frame_mem();
    logic [31:0] seen;
    int          base;
    for (int s = 0; s < 3; s++) begin
      base = s * 12 * 182;
      for (int k = 0; k < 12; k++) begin
        check("frame head byte", 32'(raw_byte(s, k)), 32'(dut.blk_mem[base + k]));
      end
      base = base + 11 * 182 + 168;
      seen = {dut.blk_mem[base], dut.blk_mem[base + 1], dut.blk_mem[base + 2], dut.blk_mem[base + 3]};
      check("check word", crc_of(s), seen);
    end
  endtask

  // Every root of each generator must give a zero syndrome over data plus parity of column 0 (outer) and row 0 (inner)
  task automatic t_parity();
    logic [14:0] r;
    logic [7:0]  a;
    logic [7:0]  syn;
    logic [7:0]  v;
    r = 15'h0020;
    for (int i = 0; i < 2048; i++) begin
      scr_tab[i] = r[7:0];
      r = scr8(r);
    end
    a = 8'h01;
    for (int k = 0; k < 16; k++) begin
      syn = 8'h00;
      for (int i = 0; i < 208; i++) begin
        v   = (i < 192) ? blk_byte(i, 0) : dut.blk_mem[i * 182];
        syn = gmul(syn, a) ^ v;
      end
      check("outer syndrome column 0", 32'h0, 32'(syn));
      if (k < 10) begin
        syn = 8'h00;
        for (int j = 0; j < 182; j++) begin
          v   = (j < 172) ? blk_byte(0, j) : dut.blk_mem[j];
          syn = gmul(syn, a) ^ v;
        end
        check("inner syndrome row 0", 32'h0, 32'(syn));
      end
      a = gmul(a, 8'h02);
    end
  endtask

  initial begin
    clk_sys    = 1'b0;
    sys_rst    = 1'b1;
    hdr_in     = '0;
    hdr_valid  = 1'b0;
    user_byte  = 8'h00;
    user_valid = 1'b0;
    num_errors = 0;
    cmp_count  = 0;
    t_reset();
    for (int s = 0; s < 16; s++) t_sector(s);
    t_first_row();
    t_frame_mem();
    t_parity();
    test_done();
  end

  // Block fill, parity phases and the first row take about 110000 cycles
  initial begin
    #520000;
    num_errors++;
    $display("mismatch watchdog expected finish seen timeout");
    test_done();
  end
endmodule
